// file: core/gig_core.sv
// Global interrupt gating: source flags, enables, global enable, stack level and vectoring
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
module gig_core
   import gig_pkg::*;
#(
   parameter int DEPTH = 8
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Program sequencer
   input wire gig_pkg::gig_seq_req_type seq_req,
   output gig_pkg::gig_seq_ans_type seq_ans,
   // Event sources
   input wire gig_pkg::gig_src_type src,
   // Interrupt to system
   output logic irq
);
   import gig_pkg::*;

   logic [7:0] flag_q;
   logic [7:0] enable_q;
   logic gie_q;
   logic [2:0] level_q;
   logic [3:0] edge_sel_q;
   logic [GIG_EV_W-1:0] status_q;
   logic [GIG_EV_W-1:0] mask_q;
   logic [11:0] stack_q [DEPTH];
   logic [11:0] ret_pc_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic load_q;
   logic [11:0] pc_value_q;
   logic in_service_q;
   logic irq_q;
   logic [5:0] ovf_sync1_q;
   logic [5:0] ovf_sync2_q;
   logic [5:0] ovf_last_q;
   logic pin0_trig;
   logic pin1_trig;
   logic [7:0] set_vec;
   logic take;
   logic do_ret;
   logic wr;
   logic rd;
   logic [2:0] level_up;
   logic [2:0] level_dn;

   // Map one set of raw source bits onto the shared register layout
   function automatic logic [7:0] gig_place(input logic [5:0] s);
      logic [7:0] v;
      v = 8'h00;
      v[GIG_BIT_PIN0] = s[0];
      v[GIG_BIT_PIN1] = s[1];
      v[GIG_BIT_TIMER0] = s[2];
      v[GIG_BIT_TC0] = s[3];
      v[GIG_BIT_TC1] = s[4];
      v[GIG_BIT_ADC] = s[5];
      return v;
   endfunction

   function automatic logic gig_hit(input logic [11:0] a, input logic [11:0] ref_a);
      return a == ref_a;
   endfunction

   gig_edge_detect u_pin0 (
      .pclk(pclk),
      .presetn(presetn),
      .pin(src.pin0),
      .edge_sel(edge_sel_q[1:0]),
      .trig(pin0_trig)
   );

   gig_edge_detect u_pin1 (
      .pclk(pclk),
      .presetn(presetn),
      .pin(src.pin1),
      .edge_sel(edge_sel_q[3:2]),
      .trig(pin1_trig)
   );

   // Internal event levels are synchronised too, so their source may be slower logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_sync1_q <= 6'h00;
         ovf_sync2_q <= 6'h00;
         ovf_last_q <= 6'h00;
      end else begin
         ovf_sync1_q <= {2'b00, src.adc_done, src.tc1_ovf, src.tc0_ovf, src.timer0_ovf};
         ovf_sync2_q <= ovf_sync1_q;
         ovf_last_q <= ovf_sync2_q;
      end
   end

   assign set_vec = gig_place({ovf_sync2_q[3:0] & ~ovf_last_q[3:0],
                               pin1_trig, pin0_trig});

   assign wr = psel & penable & pwrite & pready_q;
   assign rd = psel & penable & ~pwrite & pready_q;

   // Gate: all three conditions, taken only at a fetch boundary and never during a return
   assign take = gie_q & |(flag_q & enable_q) & seq_req.fetch & ~seq_req.ret;
   assign do_ret = seq_req.ret;
   assign level_up = level_q + 3'h1;
   assign level_dn = level_q - 3'h1;

   // Request flags: events set, software writes; set wins over a written zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= GIG_RST_SRC;
      end else if (wr && gig_hit(paddr, GIG_ADDR_FLAG)) begin
         flag_q <= (pwdata[7:0] & GIG_SRC_MASK) | set_vec;
      end else begin
         flag_q <= flag_q | set_vec;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_q <= GIG_RST_SRC;
         edge_sel_q <= 4'h0;
         mask_q <= '0;
      end else if (wr) begin
         if (gig_hit(paddr, GIG_ADDR_ENABLE)) begin
            enable_q <= pwdata[7:0] & GIG_SRC_MASK;
         end
         if (gig_hit(paddr, GIG_ADDR_EDGE)) begin
            edge_sel_q <= pwdata[3:0];
         end
         if (gig_hit(paddr, GIG_ADDR_MASK)) begin
            mask_q <= pwdata[GIG_EV_W-1:0];
         end
      end
   end

   // Global enable and stack level; hardware entry/return override a same-cycle write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gie_q <= GIG_RST_GIE;
         level_q <= GIG_RST_LEVEL;
      end else if (take) begin
         gie_q <= 1'b0;
         level_q <= level_up;
      end else if (do_ret) begin
         gie_q <= 1'b1;
         level_q <= level_dn;
      end else if (wr && gig_hit(paddr, GIG_ADDR_STACK)) begin
         gie_q <= pwdata[GIG_BIT_GIE];
         level_q <= pwdata[2:0];
      end
   end

   // Return stack, indexed by the level after push; wraps like the core stack, the wrap flagged in status bit 2
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < DEPTH; i++) begin
            stack_q[i] <= 12'h000;
         end
         ret_pc_q <= 12'h000;
      end else begin
         if (take) begin
            stack_q[level_up] <= seq_req.pc;
            ret_pc_q <= seq_req.pc;
         end
      end
   end

   // Sequencer answer, one cycle after the request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_q <= 1'b0;
         pc_value_q <= 12'h000;
         in_service_q <= 1'b0;
      end else begin
         load_q <= take | do_ret;
         if (take) begin
            pc_value_q <= GIG_VECTOR;
            in_service_q <= 1'b1;
         end else if (do_ret) begin
            pc_value_q <= stack_q[level_q];
            in_service_q <= 1'b0;
         end
      end
   end

   assign seq_ans.load = load_q;
   assign seq_ans.pc_value = pc_value_q;
   assign seq_ans.in_service = in_service_q;

   // Block event status: sticky, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= '0;
      end else begin
         logic [GIG_EV_W-1:0] ev;
         logic [GIG_EV_W-1:0] clr;
         ev = '0;
         ev[GIG_EV_ENTRY] = take;
         ev[GIG_EV_RETURN] = do_ret;
         ev[GIG_EV_WRAP] = (take && level_q == 3'h7) || (do_ret && level_q == 3'h0);
         clr = '0;
         if (wr && gig_hit(paddr, GIG_ADDR_STATUS)) begin
            clr = pwdata[GIG_EV_W-1:0];
         end
         status_q <= (status_q & ~clr) | ev;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & mask_q);
      end
   end

   // APB: zero wait states on read and write; read data is taken into a flop in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         if (psel && !penable) begin
            pready_q <= 1'b1;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            unique case (paddr)
               GIG_ADDR_FLAG: prdata_q <= {24'h0, flag_q};
               GIG_ADDR_ENABLE: prdata_q <= {24'h0, enable_q};
               GIG_ADDR_STACK: prdata_q <= {24'h0, gie_q, 4'h0, level_q};
               GIG_ADDR_EDGE: prdata_q <= {28'h0, edge_sel_q};
               GIG_ADDR_STATUS: prdata_q <= {29'h0, status_q};
               GIG_ADDR_MASK: prdata_q <= {29'h0, mask_q};
               GIG_ADDR_EVSRC: prdata_q <= {24'h0, flag_q & enable_q};
               GIG_ADDR_RETPC: prdata_q <= {20'h0, ret_pc_q};
               default: pslverr_q <= 1'b1;
            endcase
         end else if (pready_q && psel && penable) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;

   logic unused_rd;
   assign unused_rd = rd;
endmodule

// file: core/gig_pkg.sv
// Package: register map, field layout, reset values and carriers for the interrupt gating block
package gig_pkg;
   // Register byte addresses (each register takes one aligned APB word)
   localparam logic [11:0] GIG_ADDR_FLAG = 12'h320;     // 0xc8 * 4
   localparam logic [11:0] GIG_ADDR_ENABLE = 12'h324;   // 0xc9 * 4
   localparam logic [11:0] GIG_ADDR_STACK = 12'h37c;    // 0xdf * 4
   localparam logic [11:0] GIG_ADDR_EDGE = 12'h400;
   localparam logic [11:0] GIG_ADDR_STATUS = 12'h404;
   localparam logic [11:0] GIG_ADDR_MASK = 12'h408;
   localparam logic [11:0] GIG_ADDR_EVSRC = 12'h40c;
   localparam logic [11:0] GIG_ADDR_RETPC = 12'h410;
   // Register indices as printed
   localparam logic [7:0] GIG_IDX_FLAG = 8'hc8;
   localparam logic [7:0] GIG_IDX_ENABLE = 8'hc9;
   localparam logic [7:0] GIG_IDX_STACK = 8'hdf;
   // Source bit positions shared by enable and flag registers
   localparam int GIG_BIT_PIN0 = 0;
   localparam int GIG_BIT_PIN1 = 1;
   localparam int GIG_BIT_TIMER0 = 4;
   localparam int GIG_BIT_TC0 = 5;
   localparam int GIG_BIT_TC1 = 6;
   localparam int GIG_BIT_ADC = 7;
   localparam logic [7:0] GIG_SRC_MASK = 8'hf3;
   // Stack register fields, and reset value of the flag and enable registers
   localparam int GIG_BIT_GIE = 7;
   localparam logic [2:0] GIG_RST_LEVEL = 3'h7;
   localparam logic GIG_RST_GIE = 1'b0;
   localparam logic [7:0] GIG_RST_SRC = 8'h00;
   // Vector address
   localparam logic [11:0] GIG_VECTOR = 12'h008;
   // Block events into status: bit0 entry, bit1 return, bit2 stack wrap
   localparam int GIG_EV_ENTRY = 0;
   localparam int GIG_EV_RETURN = 1;
   localparam int GIG_EV_WRAP = 2;
   localparam int GIG_EV_W = 3;

   // Requests from the program sequencer
   typedef struct packed {
      logic fetch;            // Sequencer is about to fetch: vectoring may be taken here
      logic ret;              // Return-from-service instruction executed
      logic [11:0] pc;        // Address to resume at after service
   } gig_seq_req_type;

   // Answers to the program sequencer
   typedef struct packed {
      logic load;             // Load pc_value into the program counter
      logic [11:0] pc_value;
      logic in_service;
   } gig_seq_ans_type;

   // Raw event sources
   typedef struct packed {
      logic pin0;
      logic pin1;
      logic timer0_ovf;
      logic tc0_ovf;
      logic tc1_ovf;
      logic adc_done;
   } gig_src_type;
endpackage

// file: core/gig_edge_detect.sv
// Edge detector for one port pin: two-flop synchroniser, then selectable edge
`timescale 1ns/10ps
module gig_edge_detect (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pin and selection
   input wire logic pin,
   input wire logic [1:0] edge_sel,
   // Trigger pulse
   output logic trig
);
   logic sync1_q;
   logic sync2_q;
   logic last_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         sync1_q <= pin;
         sync2_q <= sync1_q;
         last_q <= sync2_q;
      end
   end

   // 00 falling, 01 rising, 1x both edges
   always_comb begin
      unique case (edge_sel)
         2'b00: trig = last_q & ~sync2_q;
         2'b01: trig = ~last_q & sync2_q;
         default: trig = last_q ^ sync2_q;
      endcase
   end
endmodule

// file: bench/gig_core_chk.sv
// Checker: port timing of the interrupt gating block
`timescale 1ns/10ps
module gig_core_chk
   import gig_pkg::*;
#(
   parameter int DEPTH = 8
) (
   // Clock, reset and APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Sequencer, sources, interrupt
   input wire gig_pkg::gig_seq_req_type seq_req,
   input wire gig_pkg::gig_seq_ans_type seq_ans,
   input wire gig_pkg::gig_src_type src,
   input wire logic irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_entry;
      seq_ans.load && seq_ans.in_service;
   endsequence
   a_ready_after_setup: assert property (s_setup |=> pready)
      else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_ready_idle: assert property (!psel |=> !pready)
      else $error("ready without request");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_vector_addr: assert property ($rose(seq_ans.in_service) |-> s_entry and seq_ans.pc_value == GIG_VECTOR)
      else $error("entry not at vector");
   a_entry_at_fetch: assert property (s_entry |-> $past(seq_req.fetch) && !$past(seq_req.ret))
      else $error("entry without fetch");
   a_entry_blocks: assert property (s_entry and !seq_req.ret |=> !seq_ans.load)
      else $error("second entry right after entry");
   a_ret_pops: assert property (seq_req.ret |=> seq_ans.load && !seq_ans.in_service)
      else $error("return not answered");
   a_return_cause: assert property (seq_ans.load && !seq_ans.in_service |-> $past(seq_req.ret))
      else $error("return load without request");
endmodule

bind gig_core gig_core_chk #(.DEPTH(DEPTH)) u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .seq_req(seq_req),
   .seq_ans(seq_ans), .src(src), .irq(irq));

// file: bench/gig_seq_model.sv
// Sequencer model: instruction boundary strobe, return pulse, resume address
`timescale 1ns/10ps
module gig_seq_model
   import gig_pkg::*;
#(
   parameter logic [11:0] RESUME = 12'h123
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control from the bench
   input wire logic do_ret,
   input wire logic slow,
   // Requests to the block
   output gig_pkg::gig_seq_req_type seq_req
);
   logic phase_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_q <= 1'b0;
      end else begin
         phase_q <= ~phase_q;
      end
   end
   // A slow sequencer reaches an instruction boundary only every other cycle
   assign seq_req.fetch = presetn && (phase_q || !slow);
   assign seq_req.ret = do_ret;
   assign seq_req.pc = RESUME;
endmodule

// file: bench/tb.sv
// Testbench: registers, source flags, gating, vectoring and return
`timescale 1ns/10ps
module tb;
   import gig_pkg::*;
   localparam logic [11:0] RESUME = 12'h123;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdata;
   logic pready, pslverr, irq, err_flag;
   logic do_ret = 1'b0;
   logic slow = 1'b0;
   logic [11:0] last_pc;
   gig_seq_req_type seq_req;
   gig_seq_ans_type seq_ans;
   gig_src_type src = 6'h30;
   int err_count = 0;
   int samples_checked = 0;
   int loads = 0;
   always #10 pclk = ~pclk;
   gig_core #(.DEPTH(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .seq_req(seq_req),
      .seq_ans(seq_ans), .src(src), .irq(irq));
   gig_seq_model #(.RESUME(RESUME)) model (.pclk(pclk), .presetn(presetn),
      .do_ret(do_ret), .slow(slow), .seq_req(seq_req));
   // Load is a one-cycle pulse, so sample it mid-cycle
   always @(negedge pclk) begin
      if (seq_ans.load === 1'b1) begin
         loads++;
         last_pc = seq_ans.pc_value;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdata = prdata;
      err_flag = pslverr;
      if (n == 20) begin
         err_count++;
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdata, exp);
   endtask
   task automatic t_reset_values();
      rd(GIG_ADDR_STACK, 32'h07);
      rd(GIG_ADDR_FLAG, 32'h0);
      rd(GIG_ADDR_ENABLE, 32'h0);
      apb(1'b1, GIG_ADDR_ENABLE, 32'hff);
      rd(GIG_ADDR_ENABLE, {24'h0, GIG_SRC_MASK});
      apb(1'b1, GIG_ADDR_ENABLE, 32'h0);
      apb(1'b0, 12'h7f0, 32'h0);
      chk({31'h0, err_flag}, 32'h1);
      chk(rdata, 32'h0);
   endtask
   task automatic t_flags_set();
      int n0;
      n0 = loads;
      apb(1'b1, GIG_ADDR_STACK, 32'h87);
      src <= 6'h0f;
      repeat (8) @(posedge pclk);
      src <= 6'h30;
      rd(GIG_ADDR_FLAG, 32'hf3);
      chk(32'(loads), 32'(n0));
      apb(1'b1, GIG_ADDR_FLAG, 32'h0);
      rd(GIG_ADDR_FLAG, 32'h0);
   endtask
   task automatic t_edges();
      apb(1'b1, GIG_ADDR_EDGE, 32'h6);
      src <= 6'h00;
      repeat (8) @(posedge pclk);
      rd(GIG_ADDR_FLAG, 32'h01);
      apb(1'b1, GIG_ADDR_FLAG, 32'h0);
      src <= 6'h30;
      repeat (8) @(posedge pclk);
      rd(GIG_ADDR_FLAG, 32'h03);
      apb(1'b1, GIG_ADDR_FLAG, 32'h0);
   endtask
   // Two pending sources; the routine picks its order and finds the next one by enable and flag
   task automatic t_priority();
      apb(1'b1, GIG_ADDR_STACK, 32'h07);
      apb(1'b1, GIG_ADDR_ENABLE, 32'h11);
      src <= 6'h18;
      repeat (8) @(posedge pclk);
      rd(GIG_ADDR_EVSRC, 32'h11);
      apb(1'b1, GIG_ADDR_FLAG, 32'h10);
      rd(GIG_ADDR_EVSRC, 32'h10);
      src <= 6'h30;
      repeat (8) @(posedge pclk);
      apb(1'b1, GIG_ADDR_FLAG, 32'h0);
      apb(1'b1, GIG_ADDR_ENABLE, 32'h0);
      rd(GIG_ADDR_FLAG, 32'h0);
   endtask
   task automatic t_vector();
      int n0;
      apb(1'b1, GIG_ADDR_STACK, 32'h01);
      apb(1'b1, GIG_ADDR_ENABLE, 32'h10);
      n0 = loads;
      src <= 6'h38;
      repeat (8) @(posedge pclk);
      chk(32'(loads), 32'(n0));
      rd(GIG_ADDR_EVSRC, 32'h10);
      apb(1'b1, GIG_ADDR_STACK, 32'h81);
      repeat (4) @(posedge pclk);
      chk(32'(loads), 32'(n0 + 1));
      chk({20'h0, last_pc}, {20'h0, GIG_VECTOR});
      rd(GIG_ADDR_STACK, 32'h02);
      apb(1'b1, GIG_ADDR_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, GIG_ADDR_MASK, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      // The service routine clears its own source before returning
      apb(1'b1, GIG_ADDR_FLAG, 32'h0);
      apb(1'b1, GIG_ADDR_STATUS, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      do_ret <= 1'b1;
      @(posedge pclk);
      do_ret <= 1'b0;
      src <= 6'h30;
      repeat (3) @(posedge pclk);
      chk({20'h0, last_pc}, {20'h0, RESUME});
      rd(GIG_ADDR_STACK, 32'h81);
      chk(32'(loads), 32'(n0 + 2));
   endtask
   task automatic results();
      $display("checks=%0d errors=%0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_values();
      t_flags_set();
      t_edges();
      t_priority();
      t_vector();
      slow <= 1'b1;
      t_vector();
      results();
   end
   initial begin
      #200000;
      err_count++;
      results();
   end
endmodule
